// *** verilog/fbc_host.sv ***
// Purpose: host-side controller driving an asynchronous parallel flash through its pins
// Assumes: pin inputs synchronous to i_clk; one request at a time
// Notes: i_addr is {A20..A0, byte address bit}; byte address bit used only in byte mode
//
// Behaviour
// - read: select and output enable low, write enable high.
// - write: write enable and select low, output enable high.
// - short-programming mode needs two write cycles per word or byte.
// - high voltage only for accelerated programming; the pin is never left floating.
// - host waits recovery time after reset before reading.
// - word address A20..A0; byte mode appends a byte address bit below.
`timescale 1ns/1ps
module fbc_host
	import fbc_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	input  wire logic              i_req,
	input  wire logic              i_write,
	input  wire logic              i_byte_mode,
	input  wire logic [ADDR_W:0]   i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_flash_reset,
	input  wire logic              i_accel_req,
	output logic                   o_ready,
	output logic                   o_rvalid,
	output logic [DATA_W-1:0]      o_rdata,
	output logic                   o_ce_n,
	output logic                   o_oe_n,
	output logic                   o_we_n,
	output logic                   o_reset_n,
	output logic                   o_byte_n,
	output logic                   o_accelerated_program,
	output logic [ADDR_W-1:0]      o_addr,
	output logic [DATA_W-1:0]      o_dq,
	output logic [DATA_W-1:0]      o_dq_oe,
	input  wire logic [DATA_W-1:0] i_dq,
	input  wire logic              i_ready_busy_out
);
	fbc_regs_s r_q;
	fbc_regs_s r_d;

	// reads refused while the high voltage is applied
	assign o_ready = (r_q.state == ST_IDLE) && !(r_q.accel && !i_write);

	always_comb begin
		r_d        = r_q;
		r_d.rvalid = 1'b0;
		r_d.rst_low = r_q.rst_n ? '0 : r_q.rst_low + CNT_W'(r_q.rst_low != '1);
		if (i_flash_reset && r_q.state != ST_RESET && r_q.state != ST_RECOV) begin
			r_d.state = ST_RESET;
			r_d.cnt   = RP_CNT;
			r_d.rst_n = 1'b0;
			r_d.ce_n  = 1'b1;
			r_d.oe_n  = 1'b1;
			r_d.we_n  = 1'b1;
			r_d.dq_oe = '0;
		end else begin
			case (r_q.state)
				ST_IDLE: begin
					if (i_req && o_ready) begin
						r_d.addr   = i_addr[ADDR_W:1];
						r_d.byte_n = !i_byte_mode;
						if (i_write) begin
							r_d.state = ST_WRITE;
							r_d.cnt   = WP_CNT;
							r_d.ce_n  = 1'b0;
							r_d.we_n  = 1'b0;
							r_d.oe_n  = 1'b1;
							if (i_byte_mode) begin
								r_d.dq_out = {i_addr[0], 7'h00, i_wdata[7:0]};
								r_d.dq_oe  = 16'h80ff;
							end else begin
								r_d.dq_out = i_wdata;
								r_d.dq_oe  = 16'hffff;
							end
						end else begin
							r_d.state  = ST_READ;
							r_d.cnt    = RD_CNT;
							r_d.ce_n   = 1'b0;
							r_d.oe_n   = 1'b0;
							r_d.we_n   = 1'b1;
							r_d.dq_out = {i_addr[0], 15'h0000};
							r_d.dq_oe  = i_byte_mode ? 16'h8000 : 16'h0000;
						end
					end else begin
						r_d.accel = i_accel_req;
					end
				end
				ST_READ: begin
					r_d.cnt = r_q.cnt - 8'h01;
					if (r_q.cnt == 8'h01) begin
						r_d.rdata  = r_q.byte_n ? i_dq : {8'h00, i_dq[7:0]};
						r_d.rvalid = 1'b1;
						r_d.ce_n   = 1'b1;
						r_d.oe_n   = 1'b1;
						r_d.dq_oe  = '0;
						r_d.state  = ST_IDLE;
					end
				end
				ST_WRITE: begin
					r_d.cnt = r_q.cnt - 8'h01;
					if (r_q.cnt == 8'h01) begin
						r_d.we_n  = 1'b1;
						r_d.ce_n  = 1'b1;
						r_d.state = ST_WHOLD;
					end
				end
				ST_WHOLD: begin
					r_d.dq_oe = '0;
					r_d.state = ST_IDLE;
				end
				ST_RESET: begin
					r_d.cnt = r_q.cnt - 8'h01;
					if (r_q.cnt == 8'h01) begin
						r_d.rst_n = 1'b1;
						r_d.cnt   = RH_CNT;
						r_d.state = ST_RECOV;
					end
				end
				ST_RECOV: begin
					if (r_q.cnt > 8'h01) begin
						r_d.cnt = r_q.cnt - 8'h01;
					end else if (i_ready_busy_out) begin
						r_d.state = ST_IDLE;
					end
				end
				default: begin
					r_d = REGS_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r_q <= REGS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	assign o_rvalid              = r_q.rvalid;
	assign o_rdata               = r_q.rdata;
	assign o_ce_n                = r_q.ce_n;
	assign o_oe_n                = r_q.oe_n;
	assign o_we_n                = r_q.we_n;
	assign o_reset_n             = r_q.rst_n;
	assign o_byte_n              = r_q.byte_n;
	assign o_accelerated_program = r_q.accel;
	assign o_addr                = r_q.addr;
	assign o_dq                  = r_q.dq_out;
	assign o_dq_oe               = r_q.dq_oe;

	a_read_levels: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_oe_n |-> !o_ce_n && o_we_n && o_reset_n)
		else $error("read without select or with write enable low");
	a_write_levels: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_we_n |-> !o_ce_n && o_oe_n && (o_dq_oe != 16'h0000))
		else $error("write enable low without select, data or with output enable low");
	// a flash reset may cut a pulse short, so those attempts are dropped
	a_write_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n || !o_reset_n)
		$fell(o_we_n) |-> !o_we_n [*2] ##1 o_we_n && o_ce_n)
		else $error("write pulse width wrong");
	a_read_access: assert property (@(posedge i_clk) disable iff (!i_reset_n || !o_reset_n)
		$fell(o_oe_n) |-> !o_oe_n [*3] ##1 (o_oe_n && o_rvalid))
		else $error("read data taken before select access time");
	a_byte_float: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_byte_n |-> o_dq_oe[14:8] == 7'h00)
		else $error("byte mode drives data lines 8 to 14");
	a_word_nobyte: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_byte_n && !o_oe_n) |-> o_dq_oe == 16'h0000)
		else $error("word read drives data lines");
	a_reset_width: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_reset_n) |-> $past(r_q.rst_low) >= RP_CNT - 8'h01)
		else $error("reset pulse shorter than minimum width");
	a_reset_recov: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_reset_n) |-> o_ce_n [*2])
		else $error("access before reset recovery");
	a_accel_noread: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_accelerated_program |-> o_oe_n)
		else $error("read while high voltage applied");

	// pin levels around reset, idle and each access
	a_reset_floats: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_reset_n |-> o_ce_n && o_oe_n && o_we_n && (o_dq_oe == 16'h0000))
		else $error("flash reset low while select, strobes or data driven");
	a_ready_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_ready |-> o_ce_n && o_reset_n)
		else $error("ready while flash selected or in reset");
	a_accel_steady: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$changed(o_accelerated_program) |-> o_ce_n && o_we_n)
		else $error("high voltage request changed during an access");
	a_byte_read_addr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!o_byte_n && !o_oe_n) |-> o_dq_oe == 16'h8000)
		else $error("byte read without byte address line driven");
	a_word_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_byte_n && !o_we_n) |-> o_dq_oe == 16'hffff)
		else $error("word write not driving all data lines");
	a_byte_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!o_byte_n && !o_we_n) |-> o_dq_oe == 16'h80ff)
		else $error("byte write driving wrong data lines");
	a_short_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_we_n) |-> o_ce_n ##1 (o_dq_oe == 16'h0000))
		else $error("write cycle not closed after write enable rise");
	a_rvalid_once: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rvalid |-> ##1 !o_rvalid)
		else $error("read valid longer than one cycle");
endmodule : fbc_host

// *** pkg/fbc_pkg.sv ***
// Purpose: shared constants and types of the flash bus host controller
// Assumes: 40 MHz system clock
// Notes: flash timing figures are plain defaults in nanoseconds
package fbc_pkg;
	localparam int unsigned CLK_MHZ          = 40;
	localparam int unsigned ADDR_W           = 21;
	localparam int unsigned DATA_W           = 16;
	localparam int unsigned CNT_W            = 8;
	// timing figures in ns
	localparam int unsigned T_ACCESS_NS      = 70;
	localparam int unsigned T_SELECT_NS      = 70;
	localparam int unsigned T_WE_PULSE_NS    = 35;
	localparam int unsigned T_RESET_MIN_NS   = 500;
	localparam int unsigned T_RESET_RECOV_NS = 50;
	// least times round up, never below one cycle
	localparam int unsigned RD_CYC   = (((T_SELECT_NS > T_ACCESS_NS ? T_SELECT_NS : T_ACCESS_NS) * CLK_MHZ + 999) / 1000);
	localparam int unsigned WP_CYC   = ((T_WE_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned RP_CYC   = ((T_RESET_MIN_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned RH_CYC   = ((T_RESET_RECOV_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC < 1 ? 1 : RD_CYC);
	localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC < 1 ? 1 : WP_CYC);
	localparam logic [CNT_W-1:0] RP_CNT = CNT_W'(RP_CYC < 1 ? 1 : RP_CYC);
	localparam logic [CNT_W-1:0] RH_CNT = CNT_W'(RH_CYC < 1 ? 1 : RH_CYC);

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_READ  = 6'h02,
		ST_WRITE = 6'h04,
		ST_WHOLD = 6'h08,
		ST_RESET = 6'h10,
		ST_RECOV = 6'h20
	} fbc_state_e;

	typedef struct packed {
		fbc_state_e              state;
		logic [CNT_W-1:0]        cnt;
		logic [CNT_W-1:0]        rst_low;
		logic [ADDR_W-1:0]       addr;
		logic [DATA_W-1:0]       dq_out;
		logic [DATA_W-1:0]       dq_oe;
		logic [DATA_W-1:0]       rdata;
		logic                    rvalid;
		logic                    ce_n;
		logic                    oe_n;
		logic                    we_n;
		logic                    rst_n;
		logic                    byte_n;
		logic                    accel;
	} fbc_regs_s;

	// flash held in reset right after host reset, so it starts in array read
	localparam fbc_regs_s REGS_RESET = '{
		state: ST_RESET, cnt: RP_CNT, rst_low: '0, addr: '0, dq_out: '0, dq_oe: '0,
		rdata: '0, rvalid: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0,
		byte_n: 1'b1, accel: 1'b0};
endpackage : fbc_pkg

// *** tb/fbc_flash_model.sv ***
// Purpose: behavioural flash on the far side of fbc_host
// Assumes: word data is {A7..A0, ~A7..A0}
// Notes: released lines show the inverse of the current read pattern
`timescale 1ns/1ps
module fbc_flash_model
	import fbc_pkg::*;
(
	input  wire logic              i_ce_n,
	input  wire logic              i_oe_n,
	input  wire logic              i_we_n,
	input  wire logic              i_reset_n,
	input  wire logic              i_byte_n,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_host_dq,
	input  wire logic [DATA_W-1:0] i_host_oe,
	output logic      [DATA_W-1:0] o_dq,
	output logic                   o_ready_busy_out
);
	logic [DATA_W-1:0] rd;
	logic [DATA_W-1:0] drv;
	logic [DATA_W-1:0] en;
	logic              wr_cyc;
	assign rd = {i_addr[7:0], ~i_addr[7:0]};
	// drive only when selected, out of reset, read levels; never gated by busy
	assign en = (!i_ce_n && !i_oe_n && i_we_n && i_reset_n) ?
		(i_byte_n ? 16'hffff : 16'h00ff) : 16'h0000;
	assign drv = i_byte_n ? rd : {8'h00, i_host_dq[15] ? rd[15:8] : rd[7:0]};
	assign o_dq = (i_host_oe & i_host_dq) | (~i_host_oe & en & drv) | (~i_host_oe & ~en & ~drv);
	// one net for the write levels, so select and strobe changing together cannot race
	assign wr_cyc = !i_ce_n && !i_we_n && i_reset_n;
	initial o_ready_busy_out = 1'b1;
	// busy for 150 ns after any program or erase write, started only while selected
	always @(posedge wr_cyc) begin
		o_ready_busy_out <= 1'b0;
		#150 o_ready_busy_out <= 1'b1;
	end
endmodule : fbc_flash_model

// *** tb/test_flash_bus_operation_control.sv ***
// Purpose: self-checking bench for fbc_host
// Assumes: inputs driven 2 ns after the rising edge
// Notes: table rows first, then flash reset and accel cases
`timescale 1ns/1ps
module test_flash_bus_operation_control
	import fbc_pkg::*;
;
	typedef struct packed {
		logic              w;
		logic              b;
		logic [ADDR_W:0]   a;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] e;
	} fbc_tb_row_s;
	logic clk = 0, rst_n = 0, req = 0, wr = 0, bm = 0, frst = 0, acc = 0;
	logic [ADDR_W:0]   a = '0;
	logic [DATA_W-1:0] wd = '0;
	logic rdy, rv, ce_n, oe_n, we_n, frn, byn, ap, rb;
	logic [DATA_W-1:0] rdat, dq, dqoe, dqi;
	logic [ADDR_W-1:0] fa;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n;
	fbc_tb_row_s rows [5] = '{
		'{1'h0, 1'h0, 22'h000154, 16'h0000, 16'haa55},
		'{1'h0, 1'h1, 22'h000154, 16'h0000, 16'h0055},
		'{1'h0, 1'h1, 22'h000155, 16'h0000, 16'h00aa},
		'{1'h1, 1'h1, 22'h000155, 16'h00a0, 16'h0000},
		'{1'h0, 1'h0, 22'h3ffffe, 16'h0000, 16'hff00}};
	always #12.5 clk = ~clk;
	fbc_host uut (.i_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_write(wr), .i_byte_mode(bm), .i_addr(a),
		.i_wdata(wd), .i_flash_reset(frst), .i_accel_req(acc), .o_ready(rdy), .o_rvalid(rv), .o_rdata(rdat),
		.o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_reset_n(frn), .o_byte_n(byn),
		.o_accelerated_program(ap), .o_addr(fa), .o_dq(dq), .o_dq_oe(dqoe), .i_dq(dqi), .i_ready_busy_out(rb));
	fbc_flash_model flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(frn), .i_byte_n(byn),
		.i_addr(fa), .i_host_dq(dq), .i_host_oe(dqoe), .o_dq(dqi), .o_ready_busy_out(rb));
	task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic step;
		@(posedge clk);
		#2;
	endtask : step
	task automatic take(input logic w, input logic b, input logic [ADDR_W:0] ad, input logic [DATA_W-1:0] d);
		wr = w;
		bm = b;
		a = ad;
		wd = d;
		n = 0;
		while (rdy !== 1'b1 && n < 200) begin
			step();
			n++;
		end
		chk(16'(rdy), 16'h0001);
		req = 1'b1;
		step();
		req = 1'b0;
	endtask : take
	task automatic xfer(input fbc_tb_row_s r);
		take(r.w, r.b, r.a, r.d);
		chk({13'h0, ce_n, oe_n, we_n}, r.w ? 16'h0002 : 16'h0001);
		chk(dqoe, r.w ? (r.b ? 16'h80ff : 16'hffff) : (r.b ? 16'h8000 : 16'h0000));
		chk({byn, fa[14:0]}, {!r.b, r.a[15:1]});
		if (r.w) chk(dq & dqoe, r.b ? {r.a[0], 7'h0, r.d[7:0]} : r.d);
		else begin
			n = 0;
			while (rv !== 1'b1 && n < 10) begin
				step();
				n++;
			end
			chk(16'(n), 16'h0003);
			chk(rdat, r.e);
		end
	endtask : xfer
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk);
		#2;
		rst_n = 1'b1;
		chk(16'(frn), 16'h0000);
		foreach (rows[i]) xfer(rows[i]);
		take(1'b0, 1'b0, 22'h000154, 16'h0000);
		frst = 1'b1;
		step();
		frst = 1'b0;
		chk({12'h0, ce_n, oe_n, we_n, frn}, 16'h000e);
		chk(dqoe, 16'h0000);
		n = 0;
		while (frn === 1'b0 && n < 100) begin
			step();
			n++;
		end
		chk(16'(n), 16'h0014);
		xfer(rows[0]);
		acc = 1'b1;
		n = 0;
		while (ap !== 1'b1 && n < 20) begin
			step();
			n++;
		end
		chk({14'h0, ap, rdy}, 16'h0002);
		xfer(fbc_tb_row_s'{1'h1, 1'h0, 22'h0002aa, 16'h5a5a, 16'h0000});
		acc = 1'b0;
		xfer(rows[4]);
		report_and_stop();
	end
endmodule : test_flash_bus_operation_control
